// ---- verilog/tsc_pkg.sv ----
/*
 * Constants for the terminal serial controller I/O block: command
 * decode, serial framing and timing.
 * Assumes one 250 MHz clock and synchronous command and line inputs.
 */
package tsc_pkg;
    // Command kinds seen on the I/O bus
    typedef enum logic [2:0]
    {
        TSC_KIND_SEL  = 3'h1,
        TSC_KIND_OUT  = 3'h2,
        TSC_KIND_IN   = 3'h3,
        TSC_KIND_AUTO = 3'h4
    } tsc_kind_e;

    localparam logic [2:0]  TSC_DEV_ADDR   = 3'h7;
    localparam logic [2:0]  TSC_FUNC_UNC   = 3'h0;
    localparam logic [2:0]  TSC_FUNC_COND  = 3'h1;
    localparam logic [2:0]  TSC_FUNC_MOTOR = 3'h7;
    localparam int          TSC_DATA_BITS  = 8;
    localparam logic [7:0]  TSC_ZERO_BYTE  = 8'h00;
    localparam logic [15:0] TSC_PTR_STEP   = 16'h0001;

    // Line timing: one bit time in cycles, from clock rate and baud
    localparam int          TSC_CLK_HZ     = 250_000_000;
    localparam int          TSC_BAUD_HZ    = 9600;
    localparam int          TSC_BIT_CYCLES = TSC_CLK_HZ / TSC_BAUD_HZ;
endpackage

// ---- verilog/tsc_tx_if.sv ----
/*
 * Load handshake between the controller core and its transmit shifter.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface tsc_tx_if;
    logic       load;
    logic [7:0] data;
    logic       busy;
    modport core  (output load, output data, input busy);
    modport shift (input load, input data, output busy);
endinterface

// ---- verilog/tsc_tx_shift.sv ----
/*
 * Transmit shifter: one start bit, eight data bits LSB first, one stop bit.
 * Assumes load arrives only while busy is low.
 */
`timescale 1ns/1ps
module tsc_tx_shift
    import tsc_pkg::*;
#(
    parameter int BIT_CYCLES = TSC_BIT_CYCLES
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Core side
    tsc_tx_if.shift   tx,
    // Line
    output logic      tx_line
);
    logic [9:0]  frame;
    logic [3:0]  bits_left;
    logic [15:0] tick;

    wire         bit_end = (tick == 16'(BIT_CYCLES - 1));

    // Busy only drops once the stop bit has fully left the line
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            frame     <= 10'h3ff;
            bits_left <= 4'h0;
            tick      <= 16'h0000;
            tx_line   <= 1'b1;
            tx.busy   <= 1'b0;
        end
        else if (tx.load)
        begin
            frame     <= {1'b1, tx.data, 1'b0};
            bits_left <= 4'ha;
            tick      <= 16'h0000;
            tx.busy   <= 1'b1;
        end
        else if (tx.busy)
        begin
            tx_line <= frame[0];
            tick    <= bit_end ? 16'h0000 : tick + 16'h0001;
            if (bit_end)
            begin
                frame     <= {1'b1, frame[9:1]};
                bits_left <= bits_left - 4'h1;
                tx.busy   <= (bits_left != 4'h1);
            end
        end
        else
        begin
            tx_line <= 1'b1;
        end
    end
endmodule // tsc_tx_shift

// ---- verilog/tsc_ctrl.sv ----
/*
 * Programmed-I/O side of the terminal serial controller: command decode,
 * one output and one input buffer, motor and request-to-send control.
 * Assumes the processor repeats a refused conditional command itself.
 */
`timescale 1ns/1ps
module tsc_ctrl
    import tsc_pkg::*;
#(
    parameter int BIT_CYCLES = TSC_BIT_CYCLES
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Option strap: RS-232 interface fitted
    input  wire logic        rs232_fitted,
    // Processor command
    input  wire logic        cmd_valid,
    input  wire logic [2:0]  cmd_dev,
    input  wire tsc_kind_e   cmd_kind,
    input  wire logic [2:0]  cmd_func,
    input  wire logic        cmd_word,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic [15:0] cmd_ptr,
    // Processor answer
    output logic             cmd_done,
    output logic             cmd_retry,
    output logic [15:0]      rd_data,
    output logic             rd_keep_high,
    output logic             mem_we,
    output logic [15:0]      mem_addr,
    output logic [15:0]      mem_wdata,
    // Terminal side
    output logic             tx_line,
    input  wire logic        rx_line,
    output logic             motor_on,
    output logic             rts,
    output logic             write_mode,
    output logic             out_empty,
    output logic             in_full
);
    tsc_tx_if txi ();

    logic       out_pend;
    logic [7:0] out_buf;
    logic [7:0] in_buf;

    // Command decode
    wire hit      = cmd_valid && (cmd_dev == TSC_DEV_ADDR);
    wire do_motor = hit && (cmd_kind == TSC_KIND_SEL) && (cmd_func == TSC_FUNC_MOTOR);
    wire do_out_u = hit && (cmd_kind == TSC_KIND_OUT) && (cmd_func == TSC_FUNC_UNC);
    wire do_out_c = hit && (cmd_kind == TSC_KIND_OUT) && (cmd_func == TSC_FUNC_COND);
    wire do_in_c  = hit && (cmd_kind == TSC_KIND_IN) && (cmd_func == TSC_FUNC_COND);
    wire do_auto  = hit && (cmd_kind == TSC_KIND_AUTO);

    // empty only when nothing pending or shifting
    wire buf_empty = !out_pend && !txi.busy;
    // conditional write needs an empty buffer
    wire wr_take   = do_out_u || (do_out_c && buf_empty);
    // conditional read needs a full buffer
    wire rd_take   = do_in_c && in_full;
    wire refuse    = (do_out_c && !buf_empty) || (do_in_c && !in_full);
    wire rx_done;
    wire [7:0] rx_byte;

    assign txi.load = out_pend && !txi.busy;
    assign txi.data = out_buf;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            out_pend <= 1'b0;
            out_buf  <= TSC_ZERO_BYTE;
        end
        else if (wr_take)
        begin
            out_pend <= 1'b1;
            out_buf  <= cmd_wdata[7:0];
        end
        else if (txi.load)
        begin
            out_pend <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            motor_on   <= 1'b0;
            rts        <= 1'b0;
            write_mode <= 1'b0;
        end
        else if (do_motor)
        begin
            motor_on   <= 1'b0;
            rts        <= rs232_fitted;
            write_mode <= 1'b1;
        end
        else if (wr_take)
        begin
            motor_on <= !rs232_fitted;
        end
    end

    // Answers; refused commands are simply reissued by the processor
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmd_done     <= 1'b0;
            cmd_retry    <= 1'b0;
            rd_data      <= 16'h0000;
            rd_keep_high <= 1'b0;
            mem_we       <= 1'b0;
            mem_addr     <= 16'h0000;
            mem_wdata    <= 16'h0000;
        end
        else
        begin
            cmd_done  <= hit && !refuse;
            cmd_retry <= refuse;
            mem_we    <= do_auto;
            if (rd_take)
            begin
                // word form zeroes the high byte
                rd_data      <= {TSC_ZERO_BYTE, in_buf};
                rd_keep_high <= !cmd_word;
            end
            if (do_auto)
            begin
                // store at incremented pointer, high byte zero
                mem_addr  <= cmd_ptr + TSC_PTR_STEP;
                mem_wdata <= {TSC_ZERO_BYTE, in_buf};
            end
        end
    end

    // full on a whole character; a new character wins over a read
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            in_full <= 1'b0;
            in_buf  <= TSC_ZERO_BYTE;
        end
        else if (rx_done)
        begin
            in_full <= 1'b1;
            in_buf  <= rx_byte;
        end
        else if (rd_take || do_auto)
        begin
            in_full <= 1'b0;
        end
    end

    // Status flag as a flop so the output is registered
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            out_empty <= 1'b1;
        else
            out_empty <= !wr_take && buf_empty && !txi.load;
    end

    // Receiver: samples mid-bit, framing errors are not reported
    logic [15:0] rx_tick;
    logic [3:0]  rx_cnt;
    logic [7:0]  rx_sh;
    logic        rx_act;
    logic        rx_fin;
    wire         rx_mid = (rx_tick == 16'(BIT_CYCLES / 2));
    assign rx_done = rx_fin;
    assign rx_byte = rx_sh;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_tick <= 16'h0000;
            rx_cnt  <= 4'h0;
            rx_sh   <= TSC_ZERO_BYTE;
            rx_act  <= 1'b0;
            rx_fin  <= 1'b0;
        end
        else
        begin
            rx_fin <= 1'b0;
            if (!rx_act)
            begin
                rx_act  <= !rx_line;
                rx_tick <= 16'h0000;
                rx_cnt  <= 4'h0;
            end
            else
            begin
                rx_tick <= (rx_tick == 16'(BIT_CYCLES - 1)) ? 16'h0000 : rx_tick + 16'h0001;
                if (rx_mid)
                begin
                    rx_cnt <= rx_cnt + 4'h1;
                    if (rx_cnt >= 4'h1 && rx_cnt <= 4'h8)
                        rx_sh <= {rx_line, rx_sh[7:1]};
                    if (rx_cnt == 4'h9)
                    begin
                        rx_act <= 1'b0;
                        rx_fin <= 1'b1;
                    end
                end
            end
        end
    end

    tsc_tx_shift #(.BIT_CYCLES(BIT_CYCLES)) u_tx
    (
        .clk     (clk),
        .rst     (rst),
        .tx      (txi),
        .tx_line (tx_line)
    );

    // Checks
    motor_cmd_a: assert property (@(posedge clk) disable iff (rst)
        do_motor |=> !motor_on && write_mode) else $error("motor command ignored");
    rts_cmd_a: assert property (@(posedge clk) disable iff (rst)
        do_motor |=> rts == $past(rs232_fitted)) else $error("rts wrong");
    out_load_a: assert property (@(posedge clk) disable iff (rst)
        do_out_u |=> out_pend && out_buf == $past(cmd_wdata[7:0])) else $error("no load");
    cond_wr_a: assert property (@(posedge clk) disable iff (rst)
        (do_out_c && !buf_empty) |=> cmd_retry && !cmd_done) else $error("busy write taken");
    cond_rd_a: assert property (@(posedge clk) disable iff (rst)
        rd_take |=> rd_data[7:0] == $past(in_buf) && cmd_done) else $error("read bad");
    word_rd_a: assert property (@(posedge clk) disable iff (rst)
        (rd_take && cmd_word) |=> !rd_keep_high && rd_data[15:8] == 8'h00)
        else $error("high byte not zero");
    auto_in_a: assert property (@(posedge clk) disable iff (rst)
        do_auto |=> mem_we && mem_addr == $past(cmd_ptr) + 16'h0001
        && mem_wdata == {8'h00, $past(in_buf)}) else $error("auto input bad");
    rx_full_a: assert property (@(posedge clk) disable iff (rst)
        rx_done |=> in_full) else $error("full not set");
    tx_empty_a: assert property (@(posedge clk) disable iff (rst)
        wr_take |=> !out_empty) else $error("empty after load");
    motor_c: cover property (@(posedge clk) disable iff (rst) do_motor);
    retry_c: cover property (@(posedge clk) disable iff (rst) cmd_retry);
    rxtx_c: cover property (@(posedge clk) disable iff (rst) rx_done ##[1:50] rd_take);
endmodule // tsc_ctrl

// ---- bench/tsc_term_model.sv ----
/*
 * Terminal model: 8N1 receiver on tx_line, sender on rx_line.
 * Assumes one clock and a bit time of BIT cycles.
 */
`timescale 1ns/1ps
module tsc_term_model
#(
    parameter int BIT = 8
)
(
    // Clock
    input  wire logic clk,
    // Serial lines
    input  wire logic tx_line,
    output logic      rx_line
);
    logic [7:0] got;
    int         nrx;

    // Idle line is mark
    initial
    begin
        rx_line = 1'b1;
        nrx     = 0;
        got     = 8'h00;
    end

    // collect sent characters
    // Mid-bit sampling tolerates a cycle of skew
    always
    begin
        @(negedge tx_line);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge clk);
            got[i] = tx_line;
        end
        repeat (BIT) @(posedge clk);
        nrx++;
    end

    // Send one frame, LSB first
    task automatic send(input logic [7:0] b);
        @(posedge clk) rx_line <= 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            repeat (BIT) @(posedge clk);
            rx_line <= (i < 8) ? b[i] : 1'b1;
        end
        repeat (BIT) @(posedge clk);
    endtask
endmodule // tsc_term_model

// ---- bench/testbench.sv ----
/*
 * Self-checking bench for the serial controller I/O block.
 * Assumes the terminal model on the line side.
 */
`timescale 1ns/1ps
module testbench;
    import tsc_pkg::*;
    localparam int B = 8;
    logic        clk, rst, fit, cv, cw, d, r;
    logic [2:0]  dev, fn;
    tsc_kind_e   kd;
    logic [15:0] wd, ptr;
    logic        done, retry, keep, we, tx, rx, mot, rts, wm, oe, inf;
    logic [15:0] rdd, maddr, mwd;
    int          mismatches, num_checks;

    tsc_ctrl #(.BIT_CYCLES(B)) uut (.clk(clk), .rst(rst), .rs232_fitted(fit),
        .cmd_valid(cv), .cmd_dev(dev), .cmd_kind(kd), .cmd_func(fn), .cmd_word(cw),
        .cmd_wdata(wd), .cmd_ptr(ptr), .cmd_done(done), .cmd_retry(retry),
        .rd_data(rdd), .rd_keep_high(keep), .mem_we(we), .mem_addr(maddr),
        .mem_wdata(mwd), .tx_line(tx), .rx_line(rx), .motor_on(mot), .rts(rts),
        .write_mode(wm), .out_empty(oe), .in_full(inf));
    tsc_term_model #(.BIT(B)) term (.clk(clk), .tx_line(tx), .rx_line(rx));

    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Count and report one comparison
    task chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    // One command pulse; answer captured a cycle later
    task cmd(input tsc_kind_e k, input logic [2:0] f, input logic w, input logic [15:0] v);
        @(posedge clk);
        cv <= 1'b1;
        kd <= k;
        fn <= f;
        cw <= w;
        wd <= v;
        @(posedge clk);
        cv <= 1'b0;
        #1;
        d = done;
        r = retry;
    endtask

    // Bounded wait for out_empty (0) or in_full (1), looked at off the edge
    task automatic wait_sig(input int sel);
        for (int i = 0; i < 14 * B && (sel ? inf : oe) !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
    endtask

    task cmd_rep(input tsc_kind_e k, input logic w, input logic [15:0] v);
        cmd(k, TSC_FUNC_COND, w, v);
        for (int i = 0; i < 14 * B && d !== 1'b1; i++)
        begin
            cmd(k, TSC_FUNC_COND, w, v);
        end
    endtask

    task t_out;
        cmd(TSC_KIND_OUT, TSC_FUNC_UNC, 1'b0, 16'h3ca5);
        chk(d === 1'b1 && oe === 1'b0, "out");
        cmd(TSC_KIND_OUT, TSC_FUNC_COND, 1'b0, 16'hff5a);
        chk(r === 1'b1 && d === 1'b0, "busy write");
        cmd_rep(TSC_KIND_OUT, 1'b0, 16'hff5a);
        chk(d === 1'b1 && mot === 1'b1, "cond write");
        chk(term.nrx === 1 && term.got === 8'ha5, "sent");
        wait_sig(0);
        chk(oe === 1'b1 && term.nrx === 2 && term.got === 8'h5a, "sent2");
        $display("test out done");
    endtask

    task t_sel;
        cmd(TSC_KIND_SEL, TSC_FUNC_MOTOR, 1'b0, 16'h0000);
        chk(d === 1'b1 && mot === 1'b0 && wm === 1'b1 && rts === 1'b0, "motor");
        @(posedge clk) fit <= 1'b1;
        cmd(TSC_KIND_SEL, TSC_FUNC_MOTOR, 1'b0, 16'h0000);
        chk(rts === 1'b1 && wm === 1'b1 && mot === 1'b0, "rts");
        $display("test sel done");
    endtask

    task t_in;
        cmd(TSC_KIND_IN, TSC_FUNC_COND, 1'b0, 16'h0000);
        chk(r === 1'b1 && d === 1'b0, "empty read");
        term.send(8'hc3);
        wait_sig(1);
        chk(inf === 1'b1, "full");
        cmd(TSC_KIND_IN, TSC_FUNC_COND, 1'b0, 16'h0000);
        chk(d === 1'b1 && rdd === 16'h00c3 && keep === 1'b1 && inf === 1'b0, "byte");
        // Word read reissued while the character is still arriving
        fork
            term.send(8'h81);
            cmd_rep(TSC_KIND_IN, 1'b1, 16'h0000);
        join
        chk(d === 1'b1 && rdd === 16'h0081 && keep === 1'b0, "word");
        $display("test in done");
    endtask

    task t_auto;
        @(posedge clk) ptr <= 16'h00ff;
        term.send(8'h7e);
        wait_sig(1);
        cmd(TSC_KIND_AUTO, TSC_FUNC_UNC, 1'b0, 16'h0000);
        chk(we === 1'b1 && maddr === 16'h0100 && mwd === 16'h007e, "auto");
        chk(inf === 1'b0, "auto clear");
        $display("test auto done");
    endtask

    // Verdict and end of run
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        {rst, fit, cv, cw, d, r} = 6'h20;
        dev = TSC_DEV_ADDR;
        fn = 3'h0;
        kd = TSC_KIND_SEL;
        wd = 16'h0000;
        ptr = 16'h0000;
        mismatches = 0;
        num_checks = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(tx === 1'b1 && oe === 1'b1 && inf === 1'b0 && wm === 1'b0, "reset");
        t_out();
        t_sel();
        t_in();
        t_auto();
        complete_run();
    end

    // Hang guard, well past the expected run
    initial
    begin
        #40000;
        mismatches++;
        complete_run();
    end
endmodule // testbench
